// [verilog/core_seq_defs.svh]
`ifndef CORE_SEQ_DEFS_SVH
`define CORE_SEQ_DEFS_SVH

// ==========================================================================
// Register offsets (the seven-bit ones are repeated in every bank)
`define OFS_INDIRECT 7'h00
`define OFS_PCL 7'h02
`define OFS_STATUS 7'h03
`define OFS_FSR 7'h04
`define OFS_PC_UPPER_LATCH 7'h0a
`define OFS_INTERRUPT_CONTROL 7'h0b
`define OFS_OPTION 8'h81
`define OFS_POWER_CONTROL_FLAGS 9'h08e
`define OFS_GPR_LO 7'h20
`define OFS_COMMON_LO 7'h70

// ==========================================================================
// Reset values, implemented-bit masks and the status write mask
`define RST_STATUS 8'h18
`define RST_FSR 8'h00
`define RST_PC_UPPER_LATCH 8'h00
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_OPTION 8'hff
`define RST_POWER_CONTROL_FLAGS 8'h08
`define MASK_PC_UPPER_LATCH 8'h1f
`define MASK_POWER_CONTROL_FLAGS 8'h0b
`define MASK_STATUS_WR 8'he7

// ==========================================================================
// Field positions
`define BIT_IRP 7
`define BIT_RP_HI 6
`define BIT_RP_LO 5
`define BIT_Z 2
`define BIT_PCH_HI 4
`define BIT_PCH_LO 3

// ==========================================================================
// Opcode classes in instruction bits 13:12
`define OPC_INCR 2'b00
`define OPC_CLEAR 2'b01
`define OPC_JUMP 2'b10
`define OPC_NOP 2'b11

`endif

// [verilog/core_seq_pkg.sv]
package core_seq_pkg;

  // ========================================================================
  // Quadrature phases, one-hot
  typedef enum logic [3:0] {
    PH_ONE = 4'b0001,
    PH_TWO = 4'b0010,
    PH_THREE = 4'b0100,
    PH_FOUR = 4'b1000
  } phase_t;

  // ========================================================================
  // Whole state of the sequencer
  typedef struct packed {
    phase_t phase;
    logic [12:0] pc;
    logic [12:0] prog_addr;
    logic [13:0] fetch;
    logic fetch_ok;
    logic [13:0] ir;
    logic ir_ok;
    logic [8:0] eff;
    logic ext;
    logic [7:0] operand;
    logic dm_rd;
    logic dm_wr;
    logic [8:0] dm_addr;
    logic [7:0] dm_wdata;
    logic [7:0] rdata;
    logic [7:0] status;
    logic [7:0] indirect_pointer;
    logic [7:0] pc_upper_latch;
    logic [7:0] interrupt_control;
    logic [7:0] option;
    logic [7:0] power_control_flags;
  } state_t;

endpackage : core_seq_pkg

// [verilog/core_cycle_pipeline_sfr_core.sv]
// Operation
// (RULE1) The clock is divided by four into phases one to four, one instruction cycle in order.
// (RULE2) The program counter steps in phase one, which starts the next fetch.
// (RULE3) The fetched word is captured from program memory in phase four.
// (RULE4) The captured word is presented in phase one and carried out in phases two to four.
// (RULE5) Fetch overlaps execution, so a plain instruction costs one instruction cycle.
// (RULE6) A jump or program-counter write costs two cycles since the prefetched word is dropped.
// (RULE7) The operand is read in phase two and the result written in phase four.
// (RULE8) The indirect location is no register; the pointer supplies the data address.
// (RULE9) Unimplemented locations and bits read as zero.
// (RULE10) The upper latch holds five writable bits; its top three bits read zero.
// (RULE11) Special registers are static storage shared by core and peripheral logic.
// (RULE12) Core registers sit at the same low offset in every bank as one register.
// (RULE13) Offsets 0x70 to 0x7f reach the same sixteen bytes in every bank.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "core_seq_defs.svh"

module core_cycle_pipeline_sfr_core (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic [13:0] PROG_DATA_I,
  output logic [12:0] PROG_ADDR_O,
  input wire logic [7:0] DMEM_RDATA_I,
  output logic DMEM_RD_O,
  output logic DMEM_WR_O,
  output logic [8:0] DMEM_ADDR_O,
  output logic [7:0] DMEM_WDATA_O,
  input wire logic [8:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic [3:0] PHASE_O,
  output logic [7:0] OPTION_O,
  output logic [7:0] INTERRUPT_CONTROL_O
);

  core_seq_pkg::state_t q;
  core_seq_pkg::state_t d;

  // ========================================================================
  // Register file helpers

  // Read of a resolved address; anything not held here reads zero
  function automatic logic [7:0] rd_core(core_seq_pkg::state_t s, logic [8:0] a);
    logic [7:0] v;
    v = 8'h00; // RULE9
    case (a[6:0]) // RULE12
      `OFS_PCL: v = s.pc[7:0];
      `OFS_STATUS: v = s.status;
      `OFS_FSR: v = s.indirect_pointer;
      `OFS_PC_UPPER_LATCH: v = s.pc_upper_latch & `MASK_PC_UPPER_LATCH; // RULE10
      `OFS_INTERRUPT_CONTROL: v = s.interrupt_control;
      default: v = 8'h00; // RULE9
    endcase
    if (a[7:0] == `OFS_OPTION) begin
      v = s.option;
    end
    if (a == `OFS_POWER_CONTROL_FLAGS) begin
      v = s.power_control_flags & `MASK_POWER_CONTROL_FLAGS; // RULE9
    end
    return v;
  endfunction : rd_core

  // Write of a resolved address; unimplemented targets ignore it
  function automatic core_seq_pkg::state_t wr_core(core_seq_pkg::state_t s, logic [8:0] a,
                                                   logic [7:0] v);
    core_seq_pkg::state_t r;
    r = s;
    case (a[6:0]) // RULE12
      `OFS_PCL: begin
        // New counter from the latch; the prefetched word is now stale
        r.pc = {s.pc_upper_latch[4:0], v}; // RULE6
        r.fetch_ok = 1'b0; // RULE6
      end
      `OFS_STATUS: r.status = (s.status & ~`MASK_STATUS_WR) | (v & `MASK_STATUS_WR);
      `OFS_FSR: r.indirect_pointer = v;
      `OFS_PC_UPPER_LATCH: r.pc_upper_latch = v & `MASK_PC_UPPER_LATCH; // RULE10
      `OFS_INTERRUPT_CONTROL: r.interrupt_control = v;
      default: r = r;
    endcase
    if (a[7:0] == `OFS_OPTION) begin
      r.option = v;
    end
    if (a == `OFS_POWER_CONTROL_FLAGS) begin
      r.power_control_flags = (s.power_control_flags & ~`MASK_POWER_CONTROL_FLAGS) | (v & `MASK_POWER_CONTROL_FLAGS);
    end
    return r;
  endfunction : wr_core

  // File field to data address, through the pointer for the indirect slot
  function automatic logic [8:0] resolve(core_seq_pkg::state_t s, logic [6:0] f);
    logic [8:0] a;
    a = {s.status[`BIT_RP_HI], s.status[`BIT_RP_LO], f};
    if (f == `OFS_INDIRECT) begin
      a = {s.status[`BIT_IRP], s.indirect_pointer}; // RULE8
    end
    if (a[6:0] >= `OFS_COMMON_LO) begin
      a = {2'b00, a[6:0]}; // RULE13
    end
    return a;
  endfunction : resolve

  // ========================================================================
  // Next-state logic
  always_comb begin
    logic [7:0] opnd;
    logic [7:0] res;
    logic [8:0] ea;
    opnd = 8'h00;
    res = 8'h00;
    ea = 9'h000;
    d = q;
    d.dm_rd = 1'b0;
    d.dm_wr = 1'b0;
    d.rdata = 8'h00;
    case (q.phase)
      core_seq_pkg::PH_ONE: begin
        d.phase = core_seq_pkg::PH_TWO; // RULE1
        d.prog_addr = q.pc;
        d.pc = q.pc + 13'h0001; // RULE2
        d.ir = q.fetch; // RULE4
        d.ir_ok = q.fetch_ok; // RULE5
        d.fetch_ok = 1'b1;
        // Operand address is settled now so memory sees the read in phase two
        if (q.fetch_ok && q.fetch[13:12] != `OPC_JUMP && q.fetch[13:12] != `OPC_NOP) begin
          ea = resolve(q, q.fetch[6:0]);
          d.eff = ea;
          d.ext = (ea[6:0] >= `OFS_GPR_LO);
          d.dm_rd = d.ext; // RULE7
          d.dm_addr = ea;
          d.operand = rd_core(q, ea); // RULE7
        end
      end
      core_seq_pkg::PH_TWO: begin
        d.phase = core_seq_pkg::PH_THREE; // RULE1
      end
      core_seq_pkg::PH_THREE: begin
        d.phase = core_seq_pkg::PH_FOUR; // RULE1
        // Result is registered here so that it lands in phase four
        if (q.ir_ok && (q.ir[13:12] == `OPC_INCR || q.ir[13:12] == `OPC_CLEAR)) begin
          opnd = q.ext ? DMEM_RDATA_I : q.operand;
          res = (q.ir[13:12] == `OPC_CLEAR) ? 8'h00 : opnd + 8'h01;
          d.status[`BIT_Z] = (res == 8'h00);
          if (q.ext) begin
            d.dm_wr = 1'b1; // RULE7
            d.dm_wdata = res;
          end else begin
            d = wr_core(d, q.eff, res); // RULE7
          end
        end
      end
      core_seq_pkg::PH_FOUR: begin
        d.phase = core_seq_pkg::PH_ONE; // RULE1
        d.fetch = PROG_DATA_I; // RULE3
        if (q.ir_ok && q.ir[13:12] == `OPC_JUMP) begin
          d.pc = {q.pc_upper_latch[`BIT_PCH_HI:`BIT_PCH_LO], q.ir[10:0]};
          d.fetch_ok = 1'b0; // RULE6
        end
      end
      default: begin
        d.phase = core_seq_pkg::PH_ONE;
      end
    endcase
    // Software port; it reaches only the core registers held here
    if (REG_RD_I) begin
      d.rdata = rd_core(q, REG_ADDR_I); // RULE9
    end
    if (REG_WR_I) begin
      d = wr_core(d, REG_ADDR_I, REG_WDATA_I); // RULE11
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      q <= '0;
      q.phase <= core_seq_pkg::PH_ONE;
      q.status <= `RST_STATUS;
      q.indirect_pointer <= `RST_FSR;
      q.pc_upper_latch <= `RST_PC_UPPER_LATCH;
      q.interrupt_control <= `RST_INTERRUPT_CONTROL;
      q.option <= `RST_OPTION;
      q.power_control_flags <= `RST_POWER_CONTROL_FLAGS;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs, all straight from the state register
  assign PROG_ADDR_O = q.prog_addr;
  assign DMEM_RD_O = q.dm_rd;
  assign DMEM_WR_O = q.dm_wr;
  assign DMEM_ADDR_O = q.dm_addr;
  assign DMEM_WDATA_O = q.dm_wdata;
  assign REG_RDATA_O = q.rdata;
  assign PHASE_O = q.phase;
  assign OPTION_O = q.option; // RULE11
  assign INTERRUPT_CONTROL_O = q.interrupt_control; // RULE11

  // ========================================================================
  // Checks

  // Phases run one to four in strict order
  property p_phase_order;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      RST_B_I && q.phase == core_seq_pkg::PH_ONE |=> q.phase == core_seq_pkg::PH_TWO
      ##1 q.phase == core_seq_pkg::PH_THREE ##1 q.phase == core_seq_pkg::PH_FOUR;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order broken"); // RULE1

  // Counter is one past the fetch address right after phase one
  property p_pc_step;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      RST_B_I && !REG_WR_I && q.phase == core_seq_pkg::PH_ONE
      |=> q.pc == q.prog_addr + 13'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter did not step in phase one"); // RULE2

  // Word on the program bus in phase four is the one held afterwards
  property p_fetch_q4;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      q.phase == core_seq_pkg::PH_FOUR |=> q.fetch == $past(PROG_DATA_I);
  endproperty
  a_fetch_q4: assert property (p_fetch_q4) else $error("fetch not captured in phase four"); // RULE3

  // Fetched word moves to the holding register at phase one
  property p_ir_present;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      q.phase == core_seq_pkg::PH_ONE && q.fetch_ok |=> q.ir == $past(q.fetch) && q.ir_ok;
  endproperty
  a_ir_present: assert property (p_ir_present) else $error("word not presented"); // RULE4 RULE5

  // Jump leaves an empty execute slot in the following cycle
  property p_jump_bubble;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      q.phase == core_seq_pkg::PH_FOUR && q.ir_ok && q.ir[13:12] == `OPC_JUMP && !REG_WR_I
      |-> ##2 !q.ir_ok;
  endproperty
  a_jump_bubble: assert property (p_jump_bubble) else $error("prefetched word kept"); // RULE6

  // Data memory strobes only in their phases
  property p_mem_phase;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      (DMEM_RD_O |-> q.phase == core_seq_pkg::PH_TWO) and
      (DMEM_WR_O |-> q.phase == core_seq_pkg::PH_FOUR);
  endproperty
  a_mem_phase: assert property (p_mem_phase) else $error("memory access in wrong phase"); // RULE7

  // Indirect slot never appears as a memory address
  property p_indirect;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      DMEM_RD_O |-> DMEM_ADDR_O[6:0] != `OFS_INDIRECT;
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect slot accessed"); // RULE8

  // Unimplemented offset reads zero
  property p_unimpl_zero;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      REG_RD_I && REG_ADDR_I[6:0] == 7'h07 |=> REG_RDATA_O == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented read not zero"); // RULE9

  // Upper latch top bits stay clear
  property p_latch_width;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      q.pc_upper_latch[7:5] == 3'b000;
  endproperty
  a_latch_width: assert property (p_latch_width) else $error("latch top bits set"); // RULE10

  // Common area always goes out as bank zero
  property p_common;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      DMEM_RD_O && DMEM_ADDR_O[6:0] >= `OFS_COMMON_LO |-> DMEM_ADDR_O[8:7] == 2'b00;
  endproperty
  a_common: assert property (p_common) else $error("common area not shared"); // RULE13

  // Phase register never holds more or less than one phase
  property p_phase_onehot;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      $onehot(q.phase);
  endproperty
  a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot"); // RULE1

  // Fetch address only moves on the phase-one edge
  property p_prog_addr_hold;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      RST_B_I && q.phase != core_seq_pkg::PH_ONE |=> $stable(PROG_ADDR_O);
  endproperty
  a_prog_addr_hold: assert property (p_prog_addr_hold) else $error("fetch moved"); // RULE2

  // Jump target is the two latch bits above the eleven address bits
  property p_jump_target;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      q.phase == core_seq_pkg::PH_FOUR && q.ir_ok && q.ir[13:12] == `OPC_JUMP && !REG_WR_I
      |=> q.pc == {$past(q.pc_upper_latch[`BIT_PCH_HI:`BIT_PCH_LO]), $past(q.ir[10:0])};
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong"); // RULE6

  // Bus write of the low counter byte reloads the counter and drops the prefetch
  property p_pcl_flush;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      REG_WR_I && REG_ADDR_I[6:0] == `OFS_PCL
      |=> !q.fetch_ok && q.pc == {$past(q.pc_upper_latch[4:0]), $past(REG_WDATA_I)};
  endproperty
  a_pcl_flush: assert property (p_pcl_flush) else $error("counter write lost"); // RULE6

  // Read strobe is a single-cycle pulse
  property p_rd_pulse;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      DMEM_RD_O |=> !DMEM_RD_O;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long"); // RULE7

  // Every operand read is written back two cycles later at the same address
  property p_rd_then_wr;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      DMEM_RD_O |-> ##2 DMEM_WR_O && DMEM_ADDR_O == $past(DMEM_ADDR_O, 2);
  endproperty
  a_rd_then_wr: assert property (p_rd_then_wr) else $error("result write missing"); // RULE7

  // Clear stores zero
  property p_wdata_clear;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      DMEM_WR_O && q.ir[13:12] == `OPC_CLEAR |-> DMEM_WDATA_O == 8'h00;
  endproperty
  a_wdata_clear: assert property (p_wdata_clear) else $error("clear wrote nonzero"); // RULE7

  // Increment stores the data taken in phase three plus one
  property p_wdata_incr;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      DMEM_WR_O && q.ir[13:12] == `OPC_INCR
      |-> DMEM_WDATA_O == $past(DMEM_RDATA_I) + 8'h01;
  endproperty
  a_wdata_incr: assert property (p_wdata_incr) else $error("increment result wrong"); // RULE7

  // Register read data stands one cycle and is zero otherwise
  property p_rdata_idle;
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      !REG_RD_I |=> REG_RDATA_O == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared"); // RULE11

endmodule : core_cycle_pipeline_sfr_core

`default_nettype wire

// [verif/core_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Program memory and banked data memory on the far side of the core
module core_mem_model (
  input wire logic clk_i,
  input wire logic [12:0] prog_addr_i,
  output logic [13:0] prog_data_o,
  input wire logic dmem_rd_i,
  input wire logic dmem_wr_i,
  input wire logic [8:0] dmem_addr_i,
  input wire logic [7:0] dmem_wdata_i,
  output logic [7:0] dmem_rdata_o
);
  logic [13:0] prog [0:15];
  logic [7:0] dmem [0:511];

  // Only sixteen words; upper bits ignored so a moved jump still loops
  assign prog_data_o = prog[prog_addr_i[3:0]];

  // Read data holds only one cycle, then scrambles so stale use shows
  always @(posedge clk_i) begin
    if (dmem_rd_i) begin
      dmem_rdata_o <= dmem[dmem_addr_i];
    end else begin
      dmem_rdata_o <= ~dmem_rdata_o;
    end
    if (dmem_wr_i) begin
      dmem[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule : core_mem_model

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [12:0] prog_addr;
  logic [13:0] prog_data;
  logic [7:0] drdata;
  logic rd;
  logic wr;
  logic [8:0] daddr;
  logic [7:0] dwdata;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr_s = 1'b0;
  logic reg_rd_s = 1'b0;
  logic [7:0] rdata;
  logic [3:0] phase;
  logic [7:0] opt;
  logic [7:0] intc;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int wr_n = 0;
  int wr_cyc [0:7];
  logic [8:0] wr_adr [0:7];
  logic [3:0] last_ph = 4'h0;
  logic [12:0] last_pa = 13'h0000;
  logic [8:0] ra [0:7] = '{9'h004, 9'h084, 9'h000, 9'h001, 9'h105, 9'h081, 9'h10b, 9'h08e};
  logic [7:0] re [0:7] = '{8'h30, 8'h30, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h08};

  // ==========================================================================
  // Clock, design and memories
  always #10 clk = ~clk;

  core_cycle_pipeline_sfr_core u_dut (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .PROG_DATA_I(prog_data), .PROG_ADDR_O(prog_addr),
    .DMEM_RDATA_I(drdata), .DMEM_RD_O(rd), .DMEM_WR_O(wr), .DMEM_ADDR_O(daddr),
    .DMEM_WDATA_O(dwdata), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_WR_I(reg_wr_s), .REG_RD_I(reg_rd_s), .REG_RDATA_O(rdata), .PHASE_O(phase),
    .OPTION_O(opt), .INTERRUPT_CONTROL_O(intc)
  );

  core_mem_model u_mem (
    .clk_i(clk), .prog_addr_i(prog_addr), .prog_data_o(prog_data), .dmem_rd_i(rd),
    .dmem_wr_i(wr), .dmem_addr_i(daddr), .dmem_wdata_i(dwdata), .dmem_rdata_o(drdata)
  );

  // ==========================================================================
  // Shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_s <= 1'b1;
    @(posedge clk);
    reg_wr_s <= 1'b0;
    #1;
  endtask : reg_wr

  // Read data is looked at only in the cycle after the strobe
  task automatic reg_rd(input logic [8:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_s <= 1'b1;
    @(posedge clk);
    reg_rd_s <= 1'b0;
    #1;
    check(nm, {8'h00, e}, {8'h00, rdata});
  endtask : reg_rd

  // ==========================================================================
  // Wire monitor on settled outputs; also cuts a hang short
  always @(negedge clk) begin
    cyc++;
    if (rst_b) begin
      if (last_ph != 4'h0) check("phase", {12'h000, last_ph[2:0], last_ph[3]}, {12'h000, phase});
      if (rd !== 1'b0) check("rd_phase", 16'h0002, {12'h000, phase});
      if (prog_addr !== last_pa) check("pc_step", 16'h0002, {12'h000, phase});
      if (wr !== 1'b0 && wr_n < 8) begin
        check("wr_phase", 16'h0008, {12'h000, phase});
        wr_cyc[wr_n] = cyc;
        wr_adr[wr_n] = daddr;
        wr_n++;
      end
    end
    last_ph = rst_b ? phase : 4'h0;
    last_pa = prog_addr;
    if (cyc > 3000) begin
      bad_count++;
      end_sim();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) u_mem.prog[i] = 14'h3000;
    for (int i = 0; i < 512; i++) u_mem.dmem[i] = i[7:0] ^ 8'h5a;
    u_mem.prog[0] = 14'h0020;
    u_mem.prog[1] = 14'h1071;
    u_mem.prog[2] = 14'h2005;
    u_mem.prog[3] = 14'h0021;
    u_mem.prog[5] = 14'h0000;
    u_mem.prog[6] = 14'h2006;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // Status is read before the first result can move the zero flag
    reg_rd(9'h003, 8'h18, "status");
    reg_rd(9'h183, 8'h18, "status_bank3");
    reg_wr(9'h104, 8'h30);
    for (int i = 0; i < 8; i++) reg_rd(ra[i], re[i], "reg_table");
    reg_rd(9'h107, 8'h00, "unimpl");
    $display("test registers done");
    for (int i = 0; i < 300 && wr_n < 3; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    check("writes", 16'h0003, wr_n[15:0]);
    check("gap_plain", 16'h0004, 16'(wr_cyc[1] - wr_cyc[0]));
    check("gap_jump", 16'h000c, 16'(wr_cyc[2] - wr_cyc[1]));
    check("adr0", 16'h0020, {7'h00, wr_adr[0]});
    check("adr1", 16'h0071, {7'h00, wr_adr[1]});
    check("adr2", 16'h0030, {7'h00, wr_adr[2]});
    check("mem20", {8'h00, 8'h20 ^ 8'h5a} + 16'h1, {8'h00, u_mem.dmem[9'h020]});
    check("mem71", 16'h0000, {8'h00, u_mem.dmem[9'h071]});
    check("mem21", {8'h00, 8'h21 ^ 8'h5a}, {8'h00, u_mem.dmem[9'h021]});
    check("mem30", {8'h00, 8'h30 ^ 8'h5a} + 16'h1, {8'h00, u_mem.dmem[9'h030]});
    $display("test pipeline done");
    reg_wr(9'h003, 8'h00);
    reg_rd(9'h083, 8'h18, "status_ro");
    reg_wr(9'h08a, 8'hff);
    reg_rd(9'h10a, 8'h1f, "upper_latch");
    reg_wr(9'h181, 8'ha5);
    check("option_out", 16'h00a5, {8'h00, opt});
    reg_rd(9'h081, 8'ha5, "option");
    reg_wr(9'h18b, 8'h81);
    check("interrupt_control_out", 16'h0081, {8'h00, intc});
    reg_wr(9'h00a, 8'h00);
    $display("test write access done");
    // Land the counter write on a phase-four edge so an in-flight jump cannot overrule it
    while (phase !== 4'b0100) begin
      @(posedge clk);
      #1;
    end
    reg_wr(9'h082, 8'h03);
    for (int i = 0; i < 300 && wr_n < 5; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    check("writes_pcl", 16'h0005, wr_n[15:0]);
    check("adr3", 16'h0021, {7'h00, wr_adr[3]});
    check("adr4", 16'h0030, {7'h00, wr_adr[4]});
    check("gap_nop", 16'h0008, 16'(wr_cyc[4] - wr_cyc[3]));
    check("mem21_pcl", {8'h00, 8'h21 ^ 8'h5a} + 16'h1, {8'h00, u_mem.dmem[9'h021]});
    $display("test counter write done");
    end_sim();
  end
endmodule : testbench

`default_nettype wire
